// [verif/emc_asserts.sv]
// port checks for the enclave metadata checker
`timescale 1ns/10ps
module emc_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        op_done_o,
    input wire logic        op_pass_o,
    input wire logic        op_fail_o
);
    logic       req, start, busy_q;
    logic [2:0] op;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign start = req && wb_we_i && wb_adr_i[11:2] == 10'h200 && !busy_q;
    assign op = wb_dat_i[2:0];
    // shadow of busy: a start while busy is refused
    always_ff @(posedge clk_i)
    begin
        if (rst_i || op_done_o)
            busy_q <= 1'b0;
        else if (start)
            busy_q <= 1'b1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_next_a: assert property (req |=> wb_ack_o)
        else $error("no ack after request");
    ack_cause_a: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    done_pulse_a: assert property (op_done_o |=> !op_done_o)
        else $error("done longer than one cycle");
    verdict_a: assert property (op_done_o |-> op_pass_o != op_fail_o)
        else $error("done without single verdict");
    wb_time_a: assert property (start && op == 3'h1 |=>
        !op_done_o [*8] ##9 op_done_o) else $error("writeback timing");
    reload_time_a: assert property (start && op == 3'h2 |->
        ##35 op_done_o) else $error("reload timing");
    tok_time_a: assert property (start && op == 3'h4 |->
        ##79 op_done_o) else $error("token timing");
    bad_cmd_a: assert property (start && op inside {3'h0, 3'h5, 3'h6,
        3'h7} |-> ##2 op_done_o && op_fail_o) else $error("bad command");
    verdict_hold_a: assert property (!start |=> op_done_o ||
        $stable({op_pass_o, op_fail_o})) else $error("verdict moved");
endmodule

// [verif/emc_sw_model.sv]
// stand-in for mac and rsa engines and launch references
`timescale 1ns/10ps
module emc_sw_model (
    input  wire logic         rsa_good_i,
    output logic              rsa_ok_o,
    output logic      [127:0] mac_o,
    output logic      [63:0]  bind_o,
    output logic      [127:0] attr_o,
    output logic      [255:0] meas_o,
    output logic      [255:0] signer_o
);
    // arbitrary patterns
    assign mac_o = {4{32'h9c3e5a17}};
    assign bind_o = {2{32'h40c2d95b}};
    assign attr_o = {4{32'h0000f3a5}};
    assign meas_o = {8{32'h6b1d7e02}};
    assign signer_o = {8{32'h2e84c6f9}};
    // good means correctly signed
    assign rsa_ok_o = rsa_good_i;
endmodule

// [verif/emc_top_test.sv]
// self-checking bench for the enclave metadata checker
`timescale 1ns/10ps
`include "emc_cfg.svh"
module emc_top_test;
    import emc_pkg::*;
    logic         clk_i, rst_i, cyc, stb, we, rg, rok, ack, done, pass, fail;
    logic [11:0]  adr;
    logic [3:0]   sel;
    logic [31:0]  dat, dat_o, lsel, rd, v;
    logic [127:0] mac, aref, ra, am;
    logic [255:0] mref, sref, em, xm;
    logic [63:0]  bid;
    logic [31:0]  img [512];
    int           mismatches, num_checks;
    int           pw[3] = '{20, 29, 16}, pb[3] = '{3, 5, 6};
    int           sw[4] = '{0, 7, 128, 12}, sb[4] = '{4, 4, 4, 3};
    int           lb[4] = '{32, 129, 260, 356};
    int           tw[7] = '{0, 0, 2, 13, 18, 33, 73};
    int           te[7] = '{7, -1, 3, 6, 6, 6, 5};
    logic [31:0]  tx[7] = '{1, 2, 1, 1, 1, 1, 1};
    logic [2:0]   bc[4] = '{0, 5, 6, 7};

    emc_sw_model u_sw (.rsa_good_i(rg), .rsa_ok_o(rok), .mac_o(mac),
        .bind_o(bid), .attr_o(aref), .meas_o(mref), .signer_o(sref));
    emc_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .mac_calc_i(mac),
        .rsa_ok_i(rok), .bind_id_i(bid), .attr_ref_i(aref),
        .meas_ref_i(mref), .signer_ref_i(sref), .op_done_o(done),
        .op_pass_o(pass), .op_fail_o(fail), .exp_meas_o(em),
        .req_attr_o(ra), .attr_mask_o(am), .launcher_sel_o(lsel));

    // ========
    // helpers
    task automatic end_sim;
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tmo;
        mismatches++;
        end_sim;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        chkw(n, 256'(e), 256'(g));
    endtask
    task automatic chkw(input string n, input logic [255:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // hold until ack is sampled, then one idle cycle
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk_i);
        if (ack !== 1'b1) tmo();
        rd = dat_o;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic run(input logic [2:0] op, input logic ok, input int b);
        int i;
        bus(1'b1, `EMC_CTRL_ADDR, 32'(op));
        rd[`EMC_ST_BUSY] = 1'b1;
        for (i = 0; i < 300 && rd[`EMC_ST_BUSY] !== 1'b0; i++)
            bus(1'b0, `EMC_STATUS_ADDR, 32'h0);
        if (rd[`EMC_ST_BUSY] !== 1'b0) tmo();
        chk("pass bit", 32'(ok), 32'(rd[`EMC_ST_PASS]));
        chk("pass port", 32'(ok), 32'(pass));
        chk("fail port", 32'(!ok), 32'(fail));
        if (b >= 0) chk("error bit", 32'h1, 32'(rd[b]));
    endtask
    task automatic load(input int n);
        for (int k = 0; k < n; k++) bus(1'b1, 12'(4*k), img[k]);
    endtask
    task automatic bad(input int w, input logic [31:0] x,
                       input logic [2:0] op, input int b);
        bus(1'b1, 12'(4*w), img[w] ^ x);
        run(op, 1'b0, b);
        bus(1'b1, 12'(4*w), img[w]);
    endtask
    // header word k, byte 0 in the low bits
    function automatic logic [31:0] hw(input logic [127:0] s, input int k);
        for (int j = 0; j < 4; j++) hw[8*j +: 8] = s[127-8*(4*k+j) -: 8];
    endfunction

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ========
    // sequence
    initial
    begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, dat} = '0;
        sel = 4'hf;
        rg = 1'b1;
        mismatches = 0;
        num_checks = 0;
        void'($urandom(32'h3844));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (img[k]) img[k] = $urandom;
        {img[17], img[16]} = bid;
        load(32);
        run(EMC_OP_WB, 1'b1, -1);
        for (int k = 18; k < 32; k++)
            img[k] = k > 27 ? mac[32*(k-28) +: 32] : 0;
        for (int k = 0; k < 32; k++)
        begin
            bus(1'b0, 12'(4*k), 32'h0);
            chk("record", img[k], rd);
        end
        run(EMC_OP_RELOAD, 1'b1, -1);
        foreach (pw[c]) bad(pw[c], 32'h1, EMC_OP_RELOAD, pb[c]);
        foreach (img[k]) img[k] = $urandom;
        for (int k = 0; k < 4; k++) img[k] = hw(`EMC_HDR1_STREAM, k);
        for (int k = 0; k < 4; k++) img[6+k] = hw(`EMC_HDR2_STREAM, k);
        for (int k = 11; k < 32; k++) img[k] = 32'h0;
        {img[225], img[227], img[248], img[249], img[250]} = '0;
        {img[251], img[257], img[258], img[259]} = '0;
        img[128] = `EMC_SIG_EXP_VAL;
        load(452);
        run(EMC_OP_SIG, 1'b1, -1);
        for (int k = 0; k < 8; k++) xm[32*k +: 32] = img[240+k];
        chkw("measurement", xm, em);
        xm = '0;
        for (int k = 0; k < 4; k++) xm[32*k +: 32] = img[232+k];
        chkw("attributes", xm, 256'(ra));
        for (int k = 0; k < 4; k++) xm[32*k +: 32] = img[236+k];
        chkw("mask", xm, 256'(am));
        for (int f = 0; f < 4; f++)
        begin
            v = f == 3 ? 95 : $urandom_range(95);
            bus(1'b1, `EMC_LIMB_ADDR, {23'h0, 2'(f), v[6:0]});
            bus(1'b0, `EMC_LDATA_ADDR, 32'h0);
            chk("limb", img[lb[f] + v], rd);
        end
        foreach (sw[c]) bad(sw[c], 32'h1, EMC_OP_SIG, sb[c]);
        rg <= 1'b0;
        run(EMC_OP_SIG, 1'b0, `EMC_ST_RSA);
        rg <= 1'b1;
        foreach (img[k]) img[k] = $urandom;
        for (int k = 0; k < 12; k++) img[k] = k == 0;
        for (int k = 0; k < 8; k++)
            {img[16+k], img[32+k]} = {mref[32*k +: 32], sref[32*k +: 32]};
        for (int k = 0; k < 4; k++)
            {img[12+k], img[72+k]} = {aref[32*k +: 32], mac[32*k +: 32]};
        load(76);
        run(EMC_OP_TOK, 1'b1, -1);
        chk("launcher select", img[59], lsel);
        foreach (tw[c])
            bad(tw[c], tx[c], EMC_OP_TOK, te[c]);
        foreach (bc[c]) run(bc[c], 1'b0, `EMC_ST_CMD);
        bus(1'b0, 12'ha00, 32'h0);
        chk("unmapped", 32'h0, rd);
        end_sim;
    end
endmodule

bind emc_top emc_asserts u_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .op_done_o, .op_pass_o,
    .op_fail_o);

// [verilog/emc_cfg.svh]
// offsets, field positions and constants of the enclave metadata checker
`ifndef EMC_CFG_SVH
`define EMC_CFG_SVH

// ========
// register map (byte addresses)
`define EMC_WIN_WORDS     512
`define EMC_CTRL_ADDR     12'h800
`define EMC_STATUS_ADDR   12'h804
`define EMC_LIMB_ADDR     12'h808
`define EMC_LDATA_ADDR    12'h80c

// ========
// status bit positions
`define EMC_ST_BUSY       0
`define EMC_ST_DONE       1
`define EMC_ST_PASS       2
`define EMC_ST_RSVD       3
`define EMC_ST_HDR        4
`define EMC_ST_MAC        5
`define EMC_ST_CMP        6
`define EMC_ST_VALID      7
`define EMC_ST_RSA        8
`define EMC_ST_CMD        9

// ========
// paging metadata record (bytes)
`define EMC_PMR_BYTES     128
`define EMC_PMR_BIND      64
`define EMC_PMR_RSVD      72
`define EMC_PMR_MAC       112
`define EMC_PMR_END       128

// ========
// signature structure (bytes)
`define EMC_SIG_BYTES     1808
`define EMC_SIG_HDR1      0
`define EMC_SIG_HDR2      24
`define EMC_SIG_RSVD0     44
`define EMC_SIG_RSVD0_END 128
`define EMC_SIG_MOD       128
`define EMC_SIG_EXP       512
`define EMC_SIG_SIGN      516
`define EMC_SIG_RSVD1     908
`define EMC_SIG_ATTR      928
`define EMC_SIG_AMASK     944
`define EMC_SIG_HASH      960
`define EMC_SIG_RSVD2     992
`define EMC_SIG_RSVD3     1028
`define EMC_SIG_Q1        1040
`define EMC_SIG_Q2        1424
`define EMC_SIG_EXP_VAL   32'h00000003
`define EMC_HDR1_STREAM   128'h06000000e10000000000010000000000
`define EMC_HDR2_STREAM   128'h01010000600000006000000001000000

// ========
// launch permission token (bytes)
`define EMC_TOK_BYTES     304
`define EMC_TOK_RSVD      4
`define EMC_TOK_ATTR      48
`define EMC_TOK_MEAS      64
`define EMC_TOK_SIGNER    128
`define EMC_TOK_FSEL      236
`define EMC_TOK_MAC       288
`define EMC_TOK_VALID_BIT 0

`endif

// [verilog/emc_chk_if.sv]
// word stream from the scanner to the field checker and its verdicts
`timescale 1ns/10ps
interface emc_chk_if;
    import emc_pkg::*;
    emc_op_e      op;
    logic [8:0]   idx;
    logic [31:0]  word;
    logic [127:0] mac;
    logic [127:0] attr;
    logic [255:0] meas;
    logic [255:0] signer;
    logic [63:0]  bind_id;
    logic         rsvd_bad;
    logic         hdr_bad;
    logic         mac_bad;
    logic         cmp_bad;
    logic         valid_bad;

    modport scan (output op, idx, word, mac, attr, meas, signer, bind_id,
                  input rsvd_bad, hdr_bad, mac_bad, cmp_bad, valid_bad);
    modport chk  (input op, idx, word, mac, attr, meas, signer, bind_id,
                  output rsvd_bad, hdr_bad, mac_bad, cmp_bad, valid_bad);
endinterface

// [verilog/emc_field_chk.sv]
// per-word field checker for the three metadata structures
`timescale 1ns/10ps
`include "emc_cfg.svh"
module emc_field_chk
    import emc_pkg::*;
(
    emc_chk_if.chk c
);
    // ========
    // helpers
    function automatic logic [31:0] pick(input logic [255:0] v,
                                         input logic [8:0]   k);
        pick = v[{k[2:0], 5'h00} +: 32];
    endfunction

    // header streams list byte 0 first; memory words are little-endian
    function automatic logic [31:0] hdr_w(input logic [127:0] s,
                                          input logic [8:0]   k);
        logic [127:0] r;
        r = '0;
        for (int b = 0; b < 16; b++)
        begin
            r[8*b +: 8] = s[127-8*b -: 8];
        end
        hdr_w = r[{k[1:0], 5'h00} +: 32];
    endfunction

    function automatic logic in_rng(input logic [8:0] i,
                                    input int lo, input int hi);
        in_rng = (int'(i) >= lo/4) && (int'(i) < hi/4);
    endfunction

    // ========
    // verdicts
    always_comb
    begin
        c.rsvd_bad  = 1'b0;
        c.hdr_bad   = 1'b0;
        c.mac_bad   = 1'b0;
        c.cmp_bad   = 1'b0;
        c.valid_bad = 1'b0;
        case (c.op)
            EMC_OP_RELOAD:
            begin
                if (in_rng(c.idx, `EMC_PMR_RSVD, `EMC_PMR_MAC))
                    c.rsvd_bad = (c.word != 32'h0); // RULE24
                if (in_rng(c.idx, `EMC_PMR_BIND, `EMC_PMR_RSVD))
                    c.cmp_bad = (c.word != pick({192'h0, c.bind_id},
                        c.idx - 9'(`EMC_PMR_BIND/4))); // RULE4
                if (in_rng(c.idx, `EMC_PMR_MAC, `EMC_PMR_END))
                    c.mac_bad = (c.word != pick({128'h0, c.mac},
                        c.idx - 9'(`EMC_PMR_MAC/4))); // RULE5
            end
            EMC_OP_SIG:
            begin
                if (in_rng(c.idx, `EMC_SIG_HDR1, `EMC_SIG_HDR1 + 16))
                    c.hdr_bad = (c.word != hdr_w(`EMC_HDR1_STREAM,
                        c.idx - 9'(`EMC_SIG_HDR1/4))); // RULE12
                if (in_rng(c.idx, `EMC_SIG_HDR2, `EMC_SIG_HDR2 + 16))
                    c.hdr_bad = (c.word != hdr_w(`EMC_HDR2_STREAM,
                        c.idx - 9'(`EMC_SIG_HDR2/4))); // RULE12
                if (int'(c.idx) == `EMC_SIG_EXP/4)
                    c.hdr_bad = (c.word != `EMC_SIG_EXP_VAL);
                if (in_rng(c.idx, `EMC_SIG_RSVD0, `EMC_SIG_RSVD0_END)
                    || in_rng(c.idx, `EMC_SIG_RSVD1, `EMC_SIG_RSVD1 + 4)
                    || in_rng(c.idx, `EMC_SIG_RSVD2, `EMC_SIG_RSVD2 + 16)
                    || in_rng(c.idx, `EMC_SIG_RSVD3, `EMC_SIG_Q1))
                    c.rsvd_bad = (c.word != 32'h0); // RULE24
            end
            EMC_OP_TOK:
            begin
                if (c.idx == 9'h0)
                begin
                    c.valid_bad = !c.word[`EMC_TOK_VALID_BIT]; // RULE19
                    c.rsvd_bad  = (c.word[31:1] != 31'h0); // RULE19
                end
                if (in_rng(c.idx, `EMC_TOK_RSVD, `EMC_TOK_ATTR))
                    c.rsvd_bad = (c.word != 32'h0); // RULE24
                if (in_rng(c.idx, `EMC_TOK_ATTR, `EMC_TOK_MEAS))
                    c.cmp_bad = (c.word != pick({128'h0, c.attr},
                        c.idx - 9'(`EMC_TOK_ATTR/4))); // RULE21
                if (in_rng(c.idx, `EMC_TOK_MEAS, `EMC_TOK_MEAS + 32))
                    c.cmp_bad = (c.word != pick(c.meas,
                        c.idx - 9'(`EMC_TOK_MEAS/4))); // RULE21
                if (in_rng(c.idx, `EMC_TOK_SIGNER, `EMC_TOK_SIGNER + 32))
                    c.cmp_bad = (c.word != pick(c.signer,
                        c.idx - 9'(`EMC_TOK_SIGNER/4))); // RULE21
                if (in_rng(c.idx, `EMC_TOK_MAC, `EMC_TOK_BYTES))
                    c.mac_bad = (c.word != pick({128'h0, c.mac},
                        c.idx - 9'(`EMC_TOK_MAC/4))); // RULE20
            end
            default: ;
        endcase
    end
endmodule

// [verilog/emc_pkg.sv]
// types shared by the enclave metadata checker
package emc_pkg;
    typedef enum logic [2:0] {
        EMC_OP_NONE   = 3'h0,
        EMC_OP_WB     = 3'h1,
        EMC_OP_RELOAD = 3'h2,
        EMC_OP_SIG    = 3'h3,
        EMC_OP_TOK    = 3'h4
    } emc_op_e;

    typedef enum logic [3:0] {
        EMC_ST_IDLE  = 4'b0001,
        EMC_ST_RUN   = 4'b0010,
        EMC_ST_DRAIN = 4'b0100,
        EMC_ST_FIN   = 4'b1000
    } emc_state_e;
endpackage

// [verilog/emc_top.sv]
// enclave metadata checker: structure window, scanner and wishbone slave
// How it works
// RULE1: paging metadata record is exactly 128 bytes
// RULE2: writeback stores mac then full record; the code only zeroes words 18-27 and writes the mac to words 28-31
// RULE3: reload reads all fields, verifies mac
// RULE4: descriptor at 0, binding id at 64
// RULE5: 16-byte mac at byte 112 covers record
// RULE6: initialise op checks the signature structure
// RULE7: measurement is 8 little-endian doublewords
// RULE8: big integers stored least significant byte first
// RULE9: signer uses rsa-3072, exponent 3, pkcs padding
// RULE10: signer supplies both helper quotients correctly
// RULE11: signature structure placed page aligned
// RULE12: two fixed 16-byte headers compared to constants
// RULE13: signature 516, quotients 1040 and 1424
// RULE14: attributes 928, mask 944, measurement 960
// RULE15: signer signs exactly the flagged fields
// RULE16: feature select 900 respects unsupported bits
// RULE17: token decides whether the enclave may launch
// RULE18: token placed 512-byte aligned
// RULE19: token word 0 bit 0 is valid
// RULE20: token mac at 288 checked with token key
// RULE21: token attributes, measurement, signer compared
// RULE22: launcher writes resolved feature select at 236
// RULE23: any failed check fails the operation
// RULE24: nonzero reserved-zero field rejects the structure
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "emc_cfg.svh"
module emc_top
    import emc_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [11:0]  wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic [127:0] mac_calc_i,
    input  wire logic         rsa_ok_i,
    input  wire logic [63:0]  bind_id_i,
    input  wire logic [127:0] attr_ref_i,
    input  wire logic [255:0] meas_ref_i,
    input  wire logic [255:0] signer_ref_i,
    output logic              op_done_o,
    output logic              op_pass_o,
    output logic              op_fail_o,
    output logic      [255:0] exp_meas_o,
    output logic      [127:0] req_attr_o,
    output logic      [127:0] attr_mask_o,
    output logic      [31:0]  launcher_sel_o
);
    // ========
    // storage and state
    logic [31:0]  mem [`EMC_WIN_WORDS];
    emc_state_e   state_q;
    emc_op_e      op_q;
    logic [8:0]   cnt_q;
    logic [8:0]   last_q;
    logic         rd_vld_q;
    logic [8:0]   rd_idx_q;
    logic [31:0]  rd_word_q;
    logic [5:0]   err_q;
    logic         done_q;
    logic         pass_q;
    logic         cmd_bad_q;
    logic [1:0]   limb_fld_q;
    logic [6:0]   limb_idx_q;
    logic         ack_q;
    logic [31:0]  rdat_q;
    logic [255:0] meas_q;
    logic [127:0] attr_q;
    logic [127:0] amask_q;
    logic [31:0]  fsel_q;
    logic         done_pulse_q;

    logic         bus_req;
    logic         bus_wr;
    logic         win_hit;
    logic [8:0]   win_idx;
    logic         start;
    logic         scan_wr;
    logic [8:0]   limb_base;
    logic [8:0]   limb_addr;
    logic         any_err;

    emc_chk_if chk ();

    // ========
    // bus decode
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign bus_wr  = bus_req && wb_we_i;
    assign win_hit = (wb_adr_i[11] == 1'b0);
    assign win_idx = wb_adr_i[10:2];
    assign start   = bus_wr && (wb_adr_i == `EMC_CTRL_ADDR) && wb_sel_i[0]
                     && (state_q == EMC_ST_IDLE);
    // writeback drives the reserved and mac words, nothing else
    assign scan_wr = (state_q == EMC_ST_RUN) && (op_q == EMC_OP_WB);

    // big integers: limb 0 is the least significant, at the field start
    always_comb
    begin
        if (limb_fld_q == 2'd0)
            limb_base = 9'(`EMC_SIG_MOD/4); // RULE8
        else if (limb_fld_q == 2'd1)
            limb_base = 9'(`EMC_SIG_SIGN/4); // RULE13
        else if (limb_fld_q == 2'd2)
            limb_base = 9'(`EMC_SIG_Q1/4); // RULE13
        else
            limb_base = 9'(`EMC_SIG_Q2/4); // RULE13
    end
    assign limb_addr = limb_base + {2'b00, limb_idx_q}; // RULE8

    // ========
    // window memory: one writer, the bus or the writeback scan
    always_ff @(posedge clk_i)
    begin
        if (scan_wr)
        begin
            if (cnt_q >= 9'(`EMC_PMR_MAC/4))
                mem[cnt_q] <= mac_calc_i[{cnt_q[1:0], 5'h00} +: 32]; // RULE5
            else
                mem[cnt_q] <= 32'h0; // RULE2
        end
        else if (bus_wr && win_hit && (state_q == EMC_ST_IDLE))
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (wb_sel_i[b])
                    mem[win_idx][8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
        end
    end

    // ========
    // wishbone answer: one wait state, ack drops the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= bus_req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_q <= 32'h0;
        else if (bus_req && !wb_we_i)
        begin
            if (win_hit)
                rdat_q <= mem[win_idx];
            else if (wb_adr_i == `EMC_STATUS_ADDR)
                rdat_q <= {22'h0, cmd_bad_q, err_q[5], err_q[4], err_q[3],
                           err_q[2], err_q[1], err_q[0], pass_q, done_q,
                           (state_q != EMC_ST_IDLE)};
            else if (wb_adr_i == `EMC_CTRL_ADDR)
                rdat_q <= {29'h0, op_q};
            else if (wb_adr_i == `EMC_LIMB_ADDR)
                rdat_q <= {23'h0, limb_fld_q, limb_idx_q};
            else if (wb_adr_i == `EMC_LDATA_ADDR)
                rdat_q <= mem[limb_addr]; // RULE8
            else
                rdat_q <= 32'h0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            limb_fld_q <= 2'd0;
            limb_idx_q <= 7'd0;
        end
        else if (bus_wr && (wb_adr_i == `EMC_LIMB_ADDR))
        begin
            if (wb_sel_i[0])
                limb_idx_q <= wb_dat_i[6:0];
            if (wb_sel_i[1])
                limb_fld_q <= wb_dat_i[8:7];
        end
    end

    // ========
    // scanner state machine
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q   <= EMC_ST_IDLE;
            op_q      <= EMC_OP_NONE;
            cnt_q     <= 9'h0;
            last_q    <= 9'h0;
            cmd_bad_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                EMC_ST_IDLE:
                begin
                    if (start)
                    begin
                        op_q      <= emc_op_e'(wb_dat_i[2:0]);
                        cmd_bad_q <= 1'b0;
                        state_q   <= EMC_ST_RUN;
                        cnt_q     <= 9'h0;
                        case (wb_dat_i[2:0])
                            3'h1:
                            begin
                                cnt_q  <= 9'(`EMC_PMR_RSVD/4); // RULE2
                                last_q <= 9'(`EMC_PMR_BYTES/4 - 1); // RULE1
                            end
                            3'h2:
                                last_q <= 9'(`EMC_PMR_BYTES/4 - 1); // RULE3
                            3'h3:
                                last_q <= 9'(`EMC_SIG_BYTES/4 - 1); // RULE6
                            3'h4:
                                last_q <= 9'(`EMC_TOK_BYTES/4 - 1); // RULE17
                            default:
                            begin
                                cmd_bad_q <= 1'b1;
                                state_q   <= EMC_ST_FIN;
                            end
                        endcase
                    end
                end
                EMC_ST_RUN:
                begin
                    cnt_q <= cnt_q + 9'h1;
                    if (cnt_q == last_q)
                        state_q <= EMC_ST_DRAIN;
                end
                EMC_ST_DRAIN:
                    state_q <= EMC_ST_FIN;
                EMC_ST_FIN:
                    state_q <= EMC_ST_IDLE;
                default:
                    state_q <= EMC_ST_IDLE;
            endcase
        end
    end

    // read pipeline: address in RUN, word one cycle later
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_vld_q  <= 1'b0;
            rd_idx_q  <= 9'h0;
            rd_word_q <= 32'h0;
        end
        else
        begin
            rd_vld_q  <= (state_q == EMC_ST_RUN) && (op_q != EMC_OP_WB);
            rd_idx_q  <= cnt_q;
            rd_word_q <= mem[cnt_q]; // RULE3
        end
    end

    // ========
    // field checker
    assign chk.op      = rd_vld_q ? op_q : EMC_OP_NONE;
    assign chk.idx     = rd_idx_q;
    assign chk.word    = rd_word_q;
    assign chk.mac     = mac_calc_i;
    assign chk.attr    = attr_ref_i;
    assign chk.meas    = meas_ref_i;
    assign chk.signer  = signer_ref_i;
    assign chk.bind_id = bind_id_i;

    emc_field_chk u_chk (
        .c (chk)
    );

    // error causes gather until the next start; a start never coincides
    // with a verdict, so no set/clear race exists
    always_ff @(posedge clk_i)
    begin
        if (rst_i || start)
            err_q <= 6'h0;
        else
        begin
            err_q[0] <= err_q[0] | chk.rsvd_bad; // RULE24
            err_q[1] <= err_q[1] | chk.hdr_bad; // RULE12
            err_q[2] <= err_q[2] | chk.mac_bad; // RULE3
            err_q[3] <= err_q[3] | chk.cmp_bad; // RULE21
            err_q[4] <= err_q[4] | chk.valid_bad; // RULE19
            if (state_q == EMC_ST_FIN && op_q == EMC_OP_SIG)
                err_q[5] <= !rsa_ok_i; // RULE6
        end
    end

    // ========
    // captured fields of the signature structure and token
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meas_q  <= 256'h0;
            attr_q  <= 128'h0;
            amask_q <= 128'h0;
            fsel_q  <= 32'h0;
        end
        else if (rd_vld_q && op_q == EMC_OP_SIG)
        begin
            if (rd_idx_q >= 9'(`EMC_SIG_HASH/4)
                && rd_idx_q < 9'(`EMC_SIG_RSVD2/4))
                meas_q[{rd_idx_q[2:0], 5'h00} +: 32] <= rd_word_q; // RULE7
            if (rd_idx_q >= 9'(`EMC_SIG_ATTR/4)
                && rd_idx_q < 9'(`EMC_SIG_AMASK/4))
                attr_q[{rd_idx_q[1:0], 5'h00} +: 32] <= rd_word_q; // RULE14
            if (rd_idx_q >= 9'(`EMC_SIG_AMASK/4)
                && rd_idx_q < 9'(`EMC_SIG_HASH/4))
                amask_q[{rd_idx_q[1:0], 5'h00} +: 32] <= rd_word_q; // RULE14
        end
        else if (rd_vld_q && op_q == EMC_OP_TOK
                 && rd_idx_q == 9'(`EMC_TOK_FSEL/4))
            fsel_q <= rd_word_q; // RULE22
    end

    // ========
    // verdict
    assign any_err = (|err_q) || cmd_bad_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            done_q       <= 1'b0;
            pass_q       <= 1'b0;
            done_pulse_q <= 1'b0;
        end
        else
        begin
            done_pulse_q <= (state_q == EMC_ST_FIN);
            if (start)
            begin
                done_q <= 1'b0;
                pass_q <= 1'b0;
            end
            else if (state_q == EMC_ST_FIN)
            begin
                done_q <= 1'b1;
                pass_q <= !any_err
                    && !(op_q == EMC_OP_SIG && !rsa_ok_i); // RULE23
            end
        end
    end

    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = rdat_q;
    assign op_done_o      = done_pulse_q;
    assign op_pass_o      = done_q && pass_q;
    assign op_fail_o      = done_q && !pass_q; // RULE23
    assign exp_meas_o     = meas_q;
    assign req_attr_o     = attr_q;
    assign attr_mask_o    = amask_q;
    assign launcher_sel_o = fsel_q;
endmodule
